//--- rtl/arrmw_pkg.sv
/*
 * arrmw_pkg: shared constants and types of the access-region
 * read-modify-write engine: bank map, command-port offsets,
 * operation codes, engine states and timing figures.
 * assumes: a single 100 MHz system clock.
 */
package arrmw_pkg;

  // ----------------------------------------------------------------
  // region map
  // ----------------------------------------------------------------
  localparam int         REGION_BANK0_BYTES  = 96;     // low part taken from bank 0
  localparam int         REGION_BANK15_BYTES = 160;    // high part taken from bank 15
  localparam logic [7:0] BANK0_LAST          = 8'h5F;  // last compact address of bank 0
  localparam logic [7:0] BANK15_FIRST        = 8'hA0;  // first held compact address of bank 15
  localparam logic [7:0] BANK0_HIGH          = 8'h00;  // upper address byte for bank 0
  localparam logic [7:0] BANK15_HIGH         = 8'h0F;  // upper address byte for bank 15
  localparam int         MEM_ENTRIES         = 256;    // one entry per compact address

  // ----------------------------------------------------------------
  // command port offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL    = 4'h0;  // operation select
  localparam logic [3:0] OFF_ADDR    = 4'h1;  // compact start address
  localparam logic [3:0] OFF_COUNT   = 4'h2;  // block length
  localparam logic [3:0] OFF_DATA    = 4'h3;  // operand, write runs one step
  localparam logic [3:0] OFF_STATUS  = 4'h4;  // busy and carry
  localparam logic [3:0] OFF_PEEK    = 4'h5;  // content at the pointer
  localparam logic [3:0] OFF_FULL_LO = 4'h6;  // expanded address, low byte
  localparam logic [3:0] OFF_FULL_HI = 4'h7;  // expanded address, high byte

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FULL_ADDR_RST = 16'h0000;
  localparam logic [7:0]  COUNT_RST     = 8'h00;
  localparam logic [7:0]  BYTE_RST      = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 10;  // sys_clk period
  localparam int         TOGGLE_GAP_NS = 83;  // spacing of the two toggles
  localparam int         TOGGLE_GAP_CYC = (TOGGLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TOGGLE_LOAD   = 4'(TOGGLE_GAP_CYC - 1);
  localparam logic [2:0] LAST_FLAG_BIT = 3'h7;
  localparam logic [2:0] CARRY_FLAG_BIT = 3'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_AND    = 3'h0,
    OP_OR     = 3'h1,
    OP_XOR    = 3'h2,
    OP_TOGGLE = 3'h3,  // double_toggle_op
    OP_ADD    = 3'h4,
    OP_FLAGS  = 3'h5   // flag_driven_unary_ops
  } arrmw_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_TOGGLE = 2'h1,
    ST_FLAGS  = 2'h2
  } arrmw_state_t;

endpackage : arrmw_pkg

//--- rtl/arrmw_unary.sv
/*
 * arrmw_unary: one step of the flag-driven unary sequence; given the
 * step index it returns the new byte, the new carry and whether the
 * location is written.
 * assumes: purely combinational, driven by the engine on one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module arrmw_unary
  import arrmw_pkg::*;
(
  // step inputs
  input  wire logic [7:0] value,
  input  wire logic       carry,
  input  wire logic [7:0] flags,
  input  wire logic [2:0] step,
  // step results
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            write_en
);

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  // each step acts on the byte as it stands after the previous one
  always_comb begin
    result    = value;
    carry_out = carry;
    write_en  = flags[step];
    case (step)
      3'h0: result = {value[6:0], value[7]};
      3'h1: result = {value[0], value[7:1]};
      3'h2: begin
        carry_out = flags[CARRY_FLAG_BIT];
        write_en  = 1'b0;
      end
      3'h3: begin
        result    = {value[6:0], carry};
        carry_out = flags[step] ? value[7] : carry;
      end
      3'h4: begin
        result    = {carry, value[7:1]};
        carry_out = flags[step] ? value[0] : carry;
      end
      3'h5: result = ~value;
      3'h6: result = 8'(~value + 8'h01);
      3'h7: result = {value[3:0], value[7:4]};
      default: result = value;
    endcase
  end

endmodule : arrmw_unary
`default_nettype wire

//--- rtl/arrmw_core.sv
/*
 * arrmw_core: access-region store with block AND/OR/XOR, double
 * toggle, single-byte add and the flag-driven unary sequence,
 * reached over a plain command port.
 * assumes: one 100 MHz clock, asynchronous active-low reset, a master
 * that issues one-cycle strobes and reads data one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - region is 96 low plus 160 high bytes; the store holds compact 0..95 and 160..255 (192 bytes)
// - 8-bit compact address expands to 16 bits
// - compact 0..95 selects bank 0
// - compact 96..255 selects bank 15
// - first byte fixes bank for whole block
// - AND/OR/XOR combine and store back in place
// - double toggle XORs twice, about 83 ns apart
// - add acts on one byte, no length
// - flag bits 0,1 rotate without carry
// - flag bit 2 is copied into carry
// - flag bits 3,4 rotate through carry
// - bits 5-7 complement, negate, swap nibbles
// - flag actions run from bit 0 up
// - each flag action is stored before next
module arrmw_core
  import arrmw_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // command port
  input  wire logic [3:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  // observation of the store
  output logic             busy,
  output logic      [15:0] full_addr,
  output logic             wr_pulse,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arrmw_op_t    op_reg;             // selected operation
  arrmw_state_t state_reg;          // engine state
  arrmw_state_t state_next;
  logic [15:0]  full_addr_reg;      // expanded address, low byte is the pointer
  logic [7:0]   count_reg;          // steps left in the block
  logic [7:0]   operand_reg;        // operand or flags of the running step
  logic [3:0]   timer_reg;          // gap counter of the double toggle
  logic [2:0]   bit_idx_reg;        // current flag step
  logic         carry_reg;          // carry flag
  logic [7:0]   rdata_reg;          // read data, one cycle after the strobe
  logic         wr_pulse_reg;       // a location was written
  logic [15:0]  wr_addr_reg;        // where it was written
  logic [7:0]   wr_data_reg;        // what was written
  logic [7:0]   mem_q [MEM_ENTRIES];// store

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        wr_ctrl   = bus_wr && (bus_addr == OFF_CTRL);
  wire        wr_addr_s = bus_wr && (bus_addr == OFF_ADDR);
  wire        wr_count  = bus_wr && (bus_addr == OFF_COUNT);
  wire        wr_data_s = bus_wr && (bus_addr == OFF_DATA);
  wire [7:0]  ptr       = full_addr_reg[7:0];
  wire        in_bank15 = (full_addr_reg[15:8] == BANK15_HIGH);
  // a location outside the two slices is not held and reads as zero
  wire        in_region = in_bank15 ? (ptr >= BANK15_FIRST) : (ptr <= BANK0_LAST);
  wire [7:0]  cur_val   = in_region ? mem_q[ptr] : BYTE_RST;
  wire        single    = (op_reg == OP_ADD) || (op_reg == OP_FLAGS);
  wire        start     = wr_data_s && (state_reg == ST_IDLE) && (count_reg != COUNT_RST);

  // compact address expansion, decided once per block
  wire [7:0]  new_high  = (bus_wdata <= BANK0_LAST) ? BANK0_HIGH : BANK15_HIGH;

  // ----------------------------------------------------------------
  // operation results
  // ----------------------------------------------------------------
  wire [7:0]  and_res   = cur_val & bus_wdata;
  wire [7:0]  or_res    = cur_val | bus_wdata;
  wire [7:0]  xor_res   = cur_val ^ bus_wdata;
  wire [7:0]  add_res   = 8'(cur_val + bus_wdata);
  wire [7:0]  tog2_res  = cur_val ^ operand_reg;
  wire [7:0]  un_res;
  wire        un_carry;
  wire        un_write;
  wire        flag_c_bit = operand_reg[CARRY_FLAG_BIT];

  // one step of the flag sequence
  arrmw_unary u_unary (
    .value     (cur_val),
    .carry     (carry_reg),
    .flags     (operand_reg),
    .step      (bit_idx_reg),
    .result    (un_res),
    .carry_out (un_carry),
    .write_en  (un_write)
  );

  // ----------------------------------------------------------------
  // engine control
  // ----------------------------------------------------------------
  wire tog_done  = (state_reg == ST_TOGGLE) && (timer_reg == 4'h0);
  wire flag_last = (state_reg == ST_FLAGS) && (bit_idx_reg == LAST_FLAG_BIT);
  wire quick     = start && (op_reg != OP_TOGGLE) && (op_reg != OP_FLAGS);
  wire advance   = quick || tog_done || flag_last;   // step over, pointer moves

  // store write port
  logic       mem_do;
  logic [7:0] mem_wdata;
  always_comb begin
    mem_do    = 1'b0;
    mem_wdata = cur_val;
    case (state_reg)
      ST_IDLE: begin
        mem_do = start;
        case (op_reg)
          OP_AND:    mem_wdata = and_res;
          OP_OR:     mem_wdata = or_res;
          OP_XOR:    mem_wdata = xor_res;
          OP_TOGGLE: mem_wdata = xor_res;      // first toggle
          OP_ADD:    mem_wdata = add_res;
          default:   mem_do    = 1'b0;         // flag sequence starts next cycle
        endcase
      end
      ST_TOGGLE: begin
        mem_do    = tog_done;                  // second toggle restores the byte
        mem_wdata = tog2_res;
      end
      ST_FLAGS: begin
        mem_do    = un_write;
        mem_wdata = un_res;
      end
      default: mem_do = 1'b0;
    endcase
  end
  wire mem_we = mem_do && in_region;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && (op_reg == OP_TOGGLE)) begin
          state_next = ST_TOGGLE;
        end else if (start && (op_reg == OP_FLAGS)) begin
          state_next = ST_FLAGS;
        end
      end
      ST_TOGGLE: if (tog_done) begin
        state_next = ST_IDLE;
      end
      ST_FLAGS: if (flag_last) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // store, one flip-flop byte per compact address
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < MEM_ENTRIES; gi++) begin : g_mem
      logic [7:0] cell_reg;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          cell_reg <= BYTE_RST;
        end else if (mem_we && (ptr == 8'(gi))) begin
          cell_reg <= mem_wdata;
        end
      end
      assign mem_q[gi] = cell_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // engine registers
  // ----------------------------------------------------------------
  // state and operation select
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_AND;
    end else begin
      state_reg <= state_next;
      if (wr_ctrl && (state_reg == ST_IDLE)) begin
        op_reg <= arrmw_op_t'(bus_wdata[2:0]);
      end
    end
  end

  // pointer and block length; only the low byte ever steps
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      full_addr_reg <= FULL_ADDR_RST;
      count_reg     <= COUNT_RST;
    end else if (state_reg == ST_IDLE && wr_ctrl) begin
      count_reg <= COUNT_RST;                  // new operation needs a new block
    end else if (state_reg == ST_IDLE && wr_addr_s) begin
      full_addr_reg <= {new_high, bus_wdata};
      if (single) begin
        count_reg <= 8'h01;
      end
    end else if (state_reg == ST_IDLE && wr_count && !single) begin
      count_reg <= bus_wdata;
    end else if (advance) begin
      full_addr_reg[7:0] <= 8'(ptr + 8'h01);
      count_reg          <= 8'(count_reg - 8'h01);
    end
  end

  // operand, toggle timer, flag step and carry
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      operand_reg <= BYTE_RST;
      timer_reg   <= 4'h0;
      bit_idx_reg <= 3'h0;
      carry_reg   <= 1'b0;
    end else if (start) begin
      operand_reg <= bus_wdata;
      timer_reg   <= TOGGLE_LOAD;
      bit_idx_reg <= 3'h0;
    end else begin
      if (state_reg == ST_TOGGLE && !tog_done) begin
        timer_reg <= 4'(timer_reg - 4'h1);
      end
      if (state_reg == ST_FLAGS) begin
        bit_idx_reg <= 3'(bit_idx_reg + 3'h1);
        carry_reg   <= un_carry;
      end
    end
  end

  // record of each store write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= FULL_ADDR_RST;
      wr_data_reg  <= BYTE_RST;
    end else begin
      wr_pulse_reg <= mem_we;
      if (mem_we) begin
        wr_addr_reg <= full_addr_reg;
        wr_data_reg <= mem_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read side of the command port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (bus_addr)
      OFF_CTRL:    rd_mux = {5'h00, op_reg};
      OFF_ADDR:    rd_mux = ptr;
      OFF_COUNT:   rd_mux = count_reg;
      OFF_STATUS:  rd_mux = {6'h00, carry_reg, (state_reg != ST_IDLE)};
      OFF_PEEK:    rd_mux = cur_val;
      OFF_FULL_LO: rd_mux = full_addr_reg[7:0];
      OFF_FULL_HI: rd_mux = full_addr_reg[15:8];
      default:     rd_mux = BYTE_RST;          // data and unmapped read zero
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= BYTE_RST;
    end else begin
      rdata_reg <= bus_rd ? rd_mux : BYTE_RST;
    end
  end

  assign bus_rdata = rdata_reg;
  assign busy      = (state_reg != ST_IDLE);
  assign full_addr = full_addr_reg;
  assign wr_pulse  = wr_pulse_reg;
  assign wr_addr   = wr_addr_reg;
  assign wr_data   = wr_data_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  bank_fixed_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !wr_addr_s |=> $stable(full_addr_reg[15:8]))
    else $error("bank changed inside a block");

  bank0_map_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_addr_s && !busy && bus_wdata <= BANK0_LAST) |=> (full_addr_reg[15:8] == BANK0_HIGH))
    else $error("low compact address not in bank 0");

  bank15_map_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_addr_s && !busy && bus_wdata >= BANK15_FIRST) |=> (full_addr_reg == {BANK15_HIGH, $past(bus_wdata)}))
    else $error("high compact address not in bank 15");

  and_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_reg == OP_AND && in_region) |=> (wr_pulse_reg && wr_data_reg == $past(and_res)))
    else $error("and result not stored");

  add_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_reg == OP_ADD && in_region) |=> (wr_data_reg == $past(add_res) && count_reg == COUNT_RST))
    else $error("add result or single-byte length wrong");

  toggle_gap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_reg == OP_TOGGLE) |=> (state_reg == ST_TOGGLE && !mem_we) [*8] ##1 (state_reg == ST_TOGGLE && mem_do) ##1 (state_reg == ST_IDLE))
    else $error("double toggle spacing wrong");

  toggle_restore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && op_reg == OP_TOGGLE && in_region) |-> ##10 (wr_data_reg == $past(cur_val, 10)))
    else $error("double toggle did not restore the byte");

  flag_order_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_FLAGS && bit_idx_reg != LAST_FLAG_BIT) |=> (bit_idx_reg == 3'($past(bit_idx_reg) + 3'h1)))
    else $error("flag steps out of order");

  carry_copy_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_FLAGS && bit_idx_reg == CARRY_FLAG_BIT) |=> (carry_reg == $past(flag_c_bit)))
    else $error("carry not taken from flag bit 2");

  flag_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_FLAGS && un_write && in_region) |=> (wr_pulse_reg && wr_data_reg == $past(un_res)))
    else $error("flag step not stored at once");

endmodule : arrmw_core
`default_nettype wire

//--- test/arrmw_host.sv
/*
 * arrmw_host: host-side model that issues one-cycle write and read
 * strobes on the command port of the engine.
 * assumes: sys_clk from the bench; tasks are called by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module arrmw_host (
  // clock
  input  wire logic       sys_clk,
  // command port
  output var  logic [3:0] bus_addr,
  output var  logic [7:0] bus_wdata,
  output var  logic       bus_wr,
  output var  logic       bus_rd,
  input  wire logic [7:0] bus_rdata
);
  // idle port at time zero
  initial begin
    bus_addr  = 4'h0;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // one write strobe; addresses are handed over as one byte only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;  // stale data must not look valid
    #1;
  endtask : wr

  // one read strobe; data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd
endmodule : arrmw_host
`default_nettype wire

//--- test/tb.sv
/*
 * tb: self-checking bench of arrmw_core: address map, block ops,
 * double toggle, add and the flag-driven sequence.
 * assumes: arrmw_host drives the command port; store is 0 after reset.
 */
`timescale 1ns/10ps
`default_nettype none
module tb
  import arrmw_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk;      // system clock
  logic        nrst;         // reset, active low
  logic [3:0]  bus_addr;     // command offset
  logic [7:0]  bus_wdata;    // write data
  logic        bus_wr;       // write strobe
  logic        bus_rd;       // read strobe
  logic [7:0]  bus_rdata;    // read data
  logic        busy;         // sequence running
  logic [15:0] full_addr;    // expanded pointer
  logic        wr_pulse;     // store written
  logic [15:0] wr_addr;      // last store address
  logic [7:0]  wr_data;      // last store value
  logic [7:0]  rv;           // read result
  logic [7:0]  seen_q[$];    // store writes observed
  int          miscompares = 0;
  int          checks = 0;

  arrmw_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .busy(busy), .full_addr(full_addr),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
  arrmw_host u_host (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // collect every store write, sampled before the edge updates
  always @(posedge sys_clk) begin
    if (wr_pulse === 1'b1) seen_q.push_back(wr_data);
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // select operation, start address and, for blocks, the length
  task automatic setup(input arrmw_op_t op, input logic [7:0] a, input logic [7:0] n);
    u_host.wr(OFF_CTRL, 8'(op));
    u_host.wr(OFF_ADDR, a);
    if (n != 8'h00) u_host.wr(OFF_COUNT, n);
  endtask : setup

  // one operand step, then expect a store write or none
  task automatic dw(input logic [7:0] d, input logic p, input logic [7:0] e);
    u_host.wr(OFF_DATA, d);
    chk(16'(wr_pulse), 16'(p));
    if (p) chk(16'(wr_data), 16'(e));
  endtask : dw

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_map;
    logic [7:0]  t [4] = '{8'h00, 8'h5F, 8'hA0, 8'hFF};
    logic [15:0] e;
    foreach (t[i]) begin
      e = (t[i] < 8'h60) ? {8'h00, t[i]} : {8'h0F, t[i]};
      u_host.wr(OFF_ADDR, t[i]);
      chk(full_addr, e);
      u_host.rd(OFF_FULL_HI, rv);
      chk(16'(rv), 16'(e[15:8]));
      u_host.rd(OFF_FULL_LO, rv);
      chk(16'(rv), 16'(e[7:0]));
    end
    u_host.rd(4'hF, rv);  // unmapped offset reads zero
    chk(16'(rv), 16'h0000);
  endtask : test_map

  // blocks crossing 95/96 stay in bank 0; outside part stores nothing
  task automatic test_block;
    setup(OP_OR, 8'h5E, 8'h03);
    dw(8'h11, 1'b1, 8'h11);
    chk(wr_addr, 16'h005E);
    dw(8'h22, 1'b1, 8'h22);
    dw(8'h33, 1'b0, 8'h00);
    chk(full_addr, 16'h0061);
    setup(OP_XOR, 8'h5E, 8'h02);
    dw(8'hFF, 1'b1, 8'hEE);
    dw(8'hFF, 1'b1, 8'hDD);
    setup(OP_AND, 8'h5F, 8'h01);
    dw(8'h0F, 1'b1, 8'h0D);
    dw(8'hFF, 1'b0, 8'h00);
    u_host.wr(OFF_ADDR, 8'h5E);
    u_host.rd(OFF_PEEK, rv);
    chk(16'(rv), 16'h00EE);
    u_host.wr(OFF_ADDR, 8'h60);
    u_host.rd(OFF_PEEK, rv);
    chk(16'(rv), 16'h0000);
  endtask : test_block

  // two writes 9 cycles apart (ceil of 83 ns), content restored
  task automatic test_toggle;
    int n;
    setup(OP_TOGGLE, 8'hA0, 8'h01);
    dw(8'h5A, 1'b1, 8'h5A);
    chk(16'(busy), 16'h0001);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (wr_pulse !== 1'b1 && n < 20);
    chk(16'(n), 16'h0009);
    chk(16'(wr_data), 16'h0000);
    chk(wr_addr, 16'h0FA0);
    chk(16'(busy), 16'h0000);
  endtask : test_toggle

  // single byte, wraps modulo 256, second operand refused
  task automatic test_add;
    setup(OP_ADD, 8'hA1, 8'h00);
    dw(8'hC8, 1'b1, 8'hC8);
    dw(8'h01, 1'b0, 8'h00);
    u_host.wr(OFF_ADDR, 8'hA1);
    dw(8'h50, 1'b1, 8'h18);
    chk(wr_addr, 16'h0FA1);
  endtask : test_add

  // flag sequences against a reference, intermediate writes included
  task automatic test_flags;
    logic [7:0] fl [9] = '{8'h01, 8'h02, 8'h0C, 8'h10, 8'h23, 8'h40, 8'h80, 8'hFF, 8'h04};
    logic [7:0] v;
    logic       c;
    logic [7:0] exp_q[$];
    int         n;
    setup(OP_ADD, 8'hA2, 8'h00);
    u_host.wr(OFF_DATA, 8'h81);
    v = 8'h81;
    c = 1'b0;
    foreach (fl[i]) begin
      exp_q.delete();
      for (int k = 0; k < 8; k++) begin
        if (k == 2) c = fl[i][2];
        else if (fl[i][k]) begin
          case (k)
            0: v = {v[6:0], v[7]};
            1: v = {v[0], v[7:1]};
            3: {c, v} = {v, c};
            4: {v, c} = {c, v};
            5: v = ~v;
            6: v = -v;
            default: v = {v[3:0], v[7:4]};
          endcase
          exp_q.push_back(v);
        end
      end
      setup(OP_FLAGS, 8'hA2, 8'h00);
      seen_q.delete();
      u_host.wr(OFF_DATA, fl[i]);
      n = 0;
      while (busy === 1'b1 && n < 20) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk(16'(n), 16'h0008);
      repeat (2) @(posedge sys_clk);
      chk(16'(seen_q.size()), 16'(exp_q.size()));
      foreach (exp_q[j]) chk(16'(seen_q[j]), 16'(exp_q[j]));
      u_host.rd(OFF_STATUS, rv);
      chk(16'(rv[1]), 16'(c));
      // the finished sequence steps the pointer on, so point back first
      u_host.wr(OFF_ADDR, 8'hA2);
      u_host.rd(OFF_PEEK, rv);
      chk(16'(rv), 16'(v));
    end
  endtask : test_flags

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    test_map();
    test_block();
    test_toggle();
    test_add();
    test_flags();
    conclude();
  end

  // whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
endmodule : tb
`default_nettype wire
